// >>> shared/pmatpc_pkg.sv
// Package of offsets, fields, reset values and encodings for the test pattern block
package pmatpc_pkg;

  // Register offsets
  localparam logic [15:0] ADDR_AUTONEG_CONTROL = 16'h0200;
  localparam logic [15:0] ADDR_PMA_CONTROL = 16'h08f6;
  localparam logic [15:0] ADDR_PMA_TEST_CONTROL = 16'h08f8;
  localparam logic [15:0] ADDR_AUTONEG_FORCED = 16'h8000;
  localparam logic [15:0] ADDR_SOFT_PD_CONTROL = 16'h8812;
  localparam logic [15:0] ADDR_SOFT_PD_STATE = 16'h8818;
  localparam logic [15:0] ADDR_TX_LEVEL = 16'h8900;

  // Field positions
  localparam int AUTONEG_ENABLE_BIT = 12;
  localparam int TX_QUIET_MODE_BIT = 14;
  localparam int TEST_PATTERN_LSB = 13;
  localparam int AUTONEG_FORCED_BIT = 0;
  localparam int SOFT_PD_REQUEST_BIT = 0;
  localparam int SOFT_PD_READY_BIT = 1;
  localparam int TX_LEVEL_HIGH_BIT = 0;

  // Values after reset
  localparam logic RST_AUTONEG_ENABLE = 1'b1;
  localparam logic RST_AUTONEG_FORCED = 1'b0;
  localparam logic RST_SOFT_PD_REQUEST = 1'b0;
  localparam logic RST_TX_QUIET = 1'b0;
  localparam logic RST_TX_LEVEL_HIGH = 1'b0;
  localparam logic [2:0] RST_TEST_PATTERN = 3'h0;

  // Counts of cycles and of symbols
  localparam int PD_ENTRY_CYCLES = 4;
  localparam int RUN_SYMBOLS = 10;

  // Test pattern codes
  typedef enum logic [2:0] {
    PAT_NORMAL = 3'b000,
    PAT_ALTERNATE = 3'b001,
    PAT_RUNS_OF_TEN = 3'b010,
    PAT_IDLE = 3'b011
  } pmatpc_pattern_t;

  // Ternary line symbols
  localparam logic [1:0] SYM_ZERO = 2'b00;
  localparam logic [1:0] SYM_PLUS = 2'b01;
  localparam logic [1:0] SYM_MINUS = 2'b11;

endpackage

// >>> verilog/pmatpc_pattern_gen.sv
// Symbol source for the alternating and run-of-ten transmit patterns
module pmatpc_pattern_gen #(
  parameter int RUN_LEN = pmatpc_pkg::RUN_SYMBOLS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sym_tick,
  input wire logic run_en,
  output logic alt_sym_neg,
  output logic run_sym_neg
);

  logic [4:0] run_cnt_r;

  // Alternating polarity every symbol: full period every two symbols
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alt_sym_neg <= 1'b0;
    end else if (!run_en) begin
      alt_sym_neg <= 1'b0;
    end else if (sym_tick) begin
      alt_sym_neg <= ~alt_sym_neg;
    end
  end

  // Polarity flips after each run, giving a twenty symbol period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_cnt_r <= 5'h00;
      run_sym_neg <= 1'b0;
    end else if (!run_en) begin
      run_cnt_r <= 5'h00;
      run_sym_neg <= 1'b0;
    end else if (sym_tick) begin
      if (run_cnt_r == 5'(RUN_LEN - 1)) begin
        run_cnt_r <= 5'h00;
        run_sym_neg <= ~run_sym_neg;
      end else begin
        run_cnt_r <= run_cnt_r + 5'h01;
      end
    end
  end

endmodule

// >>> verilog/pmatpc_top.sv
// Transmit test pattern and quiet mode control with its management registers
//
// The address-and-strobe port is this design's own decision.
module pmatpc_top #(
  parameter int PD_CYCLES = pmatpc_pkg::PD_ENTRY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic sym_tick,
  input wire logic [1:0] data_sym,
  input wire logic [1:0] idle_sym,
  output logic [1:0] line_sym,
  output logic line_level_high,
  output logic powered_down,
  output logic autoneg_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic autoneg_enable_r;
  logic autoneg_forced_mode_r;
  logic soft_powerdown_request_r;
  logic soft_powerdown_ready_r;
  logic tx_quiet_mode_enable_r;
  logic tx_level_high_r;
  logic [2:0] tx_test_pattern_select_r;
  logic [2:0] pd_cnt_r;
  logic run_en;
  logic alt_neg;
  logic run_neg;
  logic [1:0] line_sym_nxt;

  // Decode helper used by both write and read paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    return a == o;
  endfunction

  // Maps a polarity flag onto a ternary symbol
  function automatic logic [1:0] sym_of(input logic neg);
    return neg ? pmatpc_pkg::SYM_MINUS : pmatpc_pkg::SYM_PLUS;
  endfunction

  // Autonegotiation enable; the sequence itself is kept by software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      autoneg_enable_r <= pmatpc_pkg::RST_AUTONEG_ENABLE;
    end else if (reg_wr &&
                 hit(reg_addr, pmatpc_pkg::ADDR_AUTONEG_CONTROL)) begin
      autoneg_enable_r <= reg_wdata[pmatpc_pkg::AUTONEG_ENABLE_BIT];
    end
  end

  // Forced mode bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      autoneg_forced_mode_r <= pmatpc_pkg::RST_AUTONEG_FORCED;
    end else if (reg_wr &&
                 hit(reg_addr, pmatpc_pkg::ADDR_AUTONEG_FORCED)) begin
      autoneg_forced_mode_r <= reg_wdata[pmatpc_pkg::AUTONEG_FORCED_BIT];
    end
  end

  // Power-down request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      soft_powerdown_request_r <= pmatpc_pkg::RST_SOFT_PD_REQUEST;
    end else if (reg_wr &&
                 hit(reg_addr, pmatpc_pkg::ADDR_SOFT_PD_CONTROL)) begin
      soft_powerdown_request_r <= reg_wdata[pmatpc_pkg::SOFT_PD_REQUEST_BIT];
    end
  end

  // Quiet transmit enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_quiet_mode_enable_r <= pmatpc_pkg::RST_TX_QUIET;
    end else if (reg_wr && hit(reg_addr, pmatpc_pkg::ADDR_PMA_CONTROL)) begin
      tx_quiet_mode_enable_r <=
        reg_wdata[pmatpc_pkg::TX_QUIET_MODE_BIT];
    end
  end

  // Pattern select; reserved codes are stored but send normal data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_test_pattern_select_r <= pmatpc_pkg::RST_TEST_PATTERN;
    end else if (reg_wr &&
                 hit(reg_addr, pmatpc_pkg::ADDR_PMA_TEST_CONTROL)) begin
      tx_test_pattern_select_r <=
        reg_wdata[pmatpc_pkg::TEST_PATTERN_LSB +: 3];
    end
  end

  // Output amplitude choice, low level after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_level_high_r <= pmatpc_pkg::RST_TX_LEVEL_HIGH;
    end else if (reg_wr && hit(reg_addr, pmatpc_pkg::ADDR_TX_LEVEL)) begin
      tx_level_high_r <= reg_wdata[pmatpc_pkg::TX_LEVEL_HIGH_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down entry

  // Ready rises a few cycles after the request so the line settles first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pd_cnt_r <= 3'h0;
      soft_powerdown_ready_r <= 1'b0;
    end else if (!soft_powerdown_request_r) begin
      pd_cnt_r <= 3'h0;
      soft_powerdown_ready_r <= 1'b0;
    end else if (pd_cnt_r == 3'(PD_CYCLES - 1)) begin
      soft_powerdown_ready_r <= 1'b1;
    end else begin
      pd_cnt_r <= pd_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generation

  // Generators restart on each exit from power-down
  assign run_en = !soft_powerdown_request_r;

  pmatpc_pattern_gen #(
    .RUN_LEN(pmatpc_pkg::RUN_SYMBOLS)
  ) u_gen (
    .core_clk(core_clk),
    .rst(rst),
    .sym_tick(sym_tick),
    .run_en(run_en),
    .alt_sym_neg(alt_neg),
    .run_sym_neg(run_neg)
  );

  // Symbol mux; quiet wins over any pattern, power-down sends zeros
  always_comb begin
    line_sym_nxt = data_sym;
    if (soft_powerdown_request_r) begin
      line_sym_nxt = pmatpc_pkg::SYM_ZERO;
    end else if (tx_quiet_mode_enable_r) begin
      line_sym_nxt = pmatpc_pkg::SYM_ZERO;
    end else begin
      case (tx_test_pattern_select_r)
        pmatpc_pkg::PAT_ALTERNATE: begin
          line_sym_nxt = sym_of(alt_neg);
        end
        pmatpc_pkg::PAT_RUNS_OF_TEN: begin
          line_sym_nxt = sym_of(run_neg);
        end
        pmatpc_pkg::PAT_IDLE: begin
          line_sym_nxt = idle_sym;
        end
        default: begin
          line_sym_nxt = data_sym;
        end
      endcase
    end
  end

  // Registered line outputs; amplitude applies to every mode alike
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_sym <= pmatpc_pkg::SYM_ZERO;
      line_level_high <= 1'b0;
      powered_down <= 1'b0;
      autoneg_active <= 1'b0;
    end else begin
      line_sym <= line_sym_nxt;
      line_level_high <= tx_level_high_r;
      powered_down <= soft_powerdown_ready_r;
      autoneg_active <= autoneg_enable_r && !autoneg_forced_mode_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      if (hit(reg_addr, pmatpc_pkg::ADDR_AUTONEG_CONTROL)) begin
        reg_rdata[pmatpc_pkg::AUTONEG_ENABLE_BIT] <= autoneg_enable_r;
      end
      if (hit(reg_addr, pmatpc_pkg::ADDR_AUTONEG_FORCED)) begin
        reg_rdata[pmatpc_pkg::AUTONEG_FORCED_BIT] <= autoneg_forced_mode_r;
      end
      if (hit(reg_addr, pmatpc_pkg::ADDR_SOFT_PD_CONTROL)) begin
        reg_rdata[pmatpc_pkg::SOFT_PD_REQUEST_BIT] <= soft_powerdown_request_r;
      end
      if (hit(reg_addr, pmatpc_pkg::ADDR_SOFT_PD_STATE)) begin
        reg_rdata[pmatpc_pkg::SOFT_PD_READY_BIT] <= soft_powerdown_ready_r;
      end
      if (hit(reg_addr, pmatpc_pkg::ADDR_PMA_CONTROL)) begin
        reg_rdata[pmatpc_pkg::TX_QUIET_MODE_BIT] <= tx_quiet_mode_enable_r;
      end
      if (hit(reg_addr, pmatpc_pkg::ADDR_PMA_TEST_CONTROL)) begin
        reg_rdata[pmatpc_pkg::TEST_PATTERN_LSB +: 3] <=
          tx_test_pattern_select_r;
      end
      if (hit(reg_addr, pmatpc_pkg::ADDR_TX_LEVEL)) begin
        reg_rdata[pmatpc_pkg::TX_LEVEL_HIGH_BIT] <= tx_level_high_r;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Line checks watch the registered line, one cycle behind the symbol mux
  a_quiet_zero: assert property (@(posedge core_clk) disable iff (rst)
    (tx_quiet_mode_enable_r && !soft_powerdown_request_r) |=>
      line_sym == pmatpc_pkg::SYM_ZERO)
    else $error("quiet mode sent a nonzero symbol");

  a_alt_flip: assert property (@(posedge core_clk) disable iff (rst)
    (!soft_powerdown_request_r && !tx_quiet_mode_enable_r &&
     tx_test_pattern_select_r == pmatpc_pkg::PAT_ALTERNATE && sym_tick &&
     $stable(tx_test_pattern_select_r) && !$rose(run_en)) |=>
      alt_neg != $past(alt_neg))
    else $error("alternating pattern did not flip");

  a_alt_sym: assert property (@(posedge core_clk) disable iff (rst)
    (!soft_powerdown_request_r && !tx_quiet_mode_enable_r &&
     tx_test_pattern_select_r == pmatpc_pkg::PAT_ALTERNATE) |=>
      line_sym != pmatpc_pkg::SYM_ZERO)
    else $error("alternating pattern sent zero");

  a_run_sym: assert property (@(posedge core_clk) disable iff (rst)
    (!soft_powerdown_request_r && !tx_quiet_mode_enable_r &&
     tx_test_pattern_select_r == pmatpc_pkg::PAT_RUNS_OF_TEN) |=>
      line_sym == sym_of($past(run_neg)))
    else $error("run pattern symbol wrong");

  a_idle_pass: assert property (@(posedge core_clk) disable iff (rst)
    (!soft_powerdown_request_r && !tx_quiet_mode_enable_r &&
     tx_test_pattern_select_r == pmatpc_pkg::PAT_IDLE) |=>
      line_sym == $past(idle_sym))
    else $error("idle stream not passed");

  a_normal_data: assert property (@(posedge core_clk) disable iff (rst)
    (!soft_powerdown_request_r && !tx_quiet_mode_enable_r &&
     tx_test_pattern_select_r == pmatpc_pkg::PAT_NORMAL) |=>
      line_sym == $past(data_sym))
    else $error("normal data not passed");

  a_pd_ready: assert property (@(posedge core_clk) disable iff (rst)
    $rose(soft_powerdown_request_r) |->
      ##[1:8] soft_powerdown_ready_r)
    else $error("power-down ready late");

  a_pd_exit: assert property (@(posedge core_clk) disable iff (rst)
    $fell(soft_powerdown_request_r) |=> !soft_powerdown_ready_r)
    else $error("ready stayed after exit");

  a_level_follow: assert property (@(posedge core_clk) disable iff (rst)
    ##1 line_level_high == $past(tx_level_high_r))
    else $error("level output wrong");

  a_code_store: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == pmatpc_pkg::ADDR_PMA_TEST_CONTROL) |=>
      tx_test_pattern_select_r == $past(reg_wdata[15:13]))
    else $error("pattern code not stored");

  // While enabled, generators may only move on a symbol strobe; a stray step would
  // shift the pattern phase against the line symbol clock
  a_alt_steady: assert property (@(posedge core_clk) disable iff (rst)
    (run_en && !sym_tick) |=> $stable(alt_neg))
    else $error("alternating pattern moved without a tick");

  a_run_steady: assert property (@(posedge core_clk) disable iff (rst)
    (run_en && !sym_tick) |=> $stable(run_neg))
    else $error("run pattern moved without a tick");

  // Nothing but zeros may reach the line until power-down is left
  a_pd_zero: assert property (@(posedge core_clk) disable iff (rst)
    soft_powerdown_request_r |=> line_sym == pmatpc_pkg::SYM_ZERO)
    else $error("symbol sent during power-down");

endmodule

// >>> tb/pmatpc_top_test.sv
// Self-checking bench for the transmit test pattern control block
module pmatpc_top_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rst, reg_wr, reg_rd, sym_tick;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [1:0] data_sym, idle_sym, line_sym;
  logic line_level_high, powered_down, autoneg_active;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;

  pmatpc_top #(.PD_CYCLES(4)) dut (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sym_tick(sym_tick),
    .data_sym(data_sym),
    .idle_sym(idle_sym),
    .line_sym(line_sym),
    .line_level_high(line_level_high),
    .powered_down(powered_down),
    .autoneg_active(autoneg_active)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the full run needs only a few hundred cycles
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles and comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_sym(input logic [1:0] exp);
    chk({14'h0, line_sym}, {14'h0, exp});
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so grab it there
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask

  task automatic tick();
    @(posedge core_clk);
    sym_tick <= 1'b1;
    @(posedge core_clk);
    sym_tick <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // Full set-up sequence: power down, wait ready, force mode, pick, exit
  task automatic enter_mode(input logic [2:0] code, input logic quiet);
    int n;
    n = 0;
    rv = 16'h0;
    wr(16'h8812, 16'h0001);
    while (rv[1] !== 1'b1 && n < 20) begin
      rd(16'h8818);
      n++;
    end
    chk({15'h0, rv[1]}, 16'h0001);
    chk({15'h0, powered_down}, 16'h0001);
    chk_sym(pmatpc_pkg::SYM_ZERO);
    wr(16'h0200, 16'h0000);
    wr(16'h8000, 16'h0001);
    wr(16'h08f8, {code, 13'h0});
    wr(16'h08f6, {1'b0, quiet, 14'h0});
    wr(16'h8812, 16'h0000);
    rd(16'h8818);
    chk({15'h0, rv[1]}, 16'h0000);
    chk({15'h0, autoneg_active}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    logic [15:0] adr [8];
    logic [15:0] exp [8];
    adr = '{16'h0200, 16'h8000, 16'h8812, 16'h8818, 16'h08f6, 16'h08f8,
            16'h8900, 16'h1234};
    exp = '{16'h1000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    for (int i = 0; i < 8; i++) begin
      rd(adr[i]);
      chk(rv, exp[i]);
    end
    chk({15'h0, autoneg_active}, 16'h0001);
  endtask

  task automatic test_alternate();
    enter_mode(3'b001, 1'b0);
    chk_sym(pmatpc_pkg::SYM_PLUS);
    for (int k = 1; k <= 6; k++) begin
      tick();
      chk_sym(k % 2 ? pmatpc_pkg::SYM_MINUS : pmatpc_pkg::SYM_PLUS);
    end
    // Amplitude change must not disturb the running pattern
    wr(16'h8900, 16'h0001);
    tick();
    chk({15'h0, line_level_high}, 16'h0001);
    chk_sym(pmatpc_pkg::SYM_MINUS);
  endtask

  task automatic test_runs();
    enter_mode(3'b010, 1'b0);
    chk_sym(pmatpc_pkg::SYM_PLUS);
    for (int k = 1; k <= 40; k++) begin
      tick();
      chk_sym((k / 10) % 2 ? pmatpc_pkg::SYM_MINUS :
              pmatpc_pkg::SYM_PLUS);
    end
  endtask

  task automatic test_idle();
    logic [1:0] v [3];
    v = '{pmatpc_pkg::SYM_PLUS, pmatpc_pkg::SYM_MINUS, pmatpc_pkg::SYM_ZERO};
    enter_mode(3'b011, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      idle_sym <= v[i];
      repeat (2) @(posedge core_clk);
      #1;
      chk_sym(v[i]);
    end
  endtask

  task automatic test_quiet();
    enter_mode(3'b001, 1'b1);
    rd(16'h08f6);
    chk(rv, 16'h4000);
    for (int k = 0; k < 3; k++) begin
      tick();
      chk_sym(pmatpc_pkg::SYM_ZERO);
    end
  endtask

  // Code 000 and the reserved codes carry normal data
  task automatic test_normal();
    logic [2:0] c [5];
    c = '{3'b000, 3'b100, 3'b101, 3'b110, 3'b111};
    for (int i = 0; i < 5; i++) begin
      enter_mode(c[i], 1'b0);
      @(posedge core_clk);
      data_sym <= pmatpc_pkg::SYM_MINUS;
      repeat (2) @(posedge core_clk);
      #1;
      chk_sym(pmatpc_pkg::SYM_MINUS);
      tick();
      chk_sym(pmatpc_pkg::SYM_MINUS);
      // Inputs move only on a rising edge, never mid-cycle
      @(posedge core_clk);
      data_sym <= pmatpc_pkg::SYM_ZERO;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 16'h0;
    sym_tick = 1'b0;
    data_sym = pmatpc_pkg::SYM_ZERO;
    idle_sym = pmatpc_pkg::SYM_ZERO;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_alternate();
    test_runs();
    test_idle();
    test_quiet();
    test_normal();
    wrap_up();
  end
endmodule
